// File: design/jtl_transport_mapper.sv
// jtl_transport_mapper: sample fifo, frame packer and two eight-lane links
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////
module jtl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  // drain side
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [WIDTH-1:0]      rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;
  logic             push;
  logic             pop;

  // honest flags from the occupancy count
  assign wr_ready = cnt != (AW+1)'(DEPTH);
  assign rd_valid = cnt != '0;
  assign rd_data  = mem[rp];
  assign push     = wr_valid && wr_ready;
  assign pop      = rd_valid && rd_ready;

  // storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp] <= wr_data;
    end
  end

  // pointers and count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
      end
      if (push && !pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop && !push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  a_fifo_no_over : assert property (@(posedge ref_clk) disable iff (rst)
    (cnt == (AW+1)'(DEPTH) && !pop) |=> cnt == (AW+1)'(DEPTH))
    else $error("fifo count moved while full");
endmodule

////////////////////////////////////////////////////////////////////////
module jtl_transport_mapper
  import jtl_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // sample stream in
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire jtl_beat_t         in_beat,
  // link a lanes
  output logic [LANES-1:0][7:0]  link_a_lane,
  output logic [LANES-1:0]       link_a_lane_en,
  output logic [LANES-1:0][2:0]  link_a_lane_id,
  output logic [7:0]             link_a_did,
  // link b lanes
  output logic [LANES-1:0][7:0]  link_b_lane,
  output logic [LANES-1:0]       link_b_lane_en,
  output logic [LANES-1:0][2:0]  link_b_lane_id,
  output logic [7:0]             link_b_did,
  // framing marks, common to both links
  output logic                   octet_valid,
  output logic                   frame_start,
  output logic                   multiframe_end
);
  // control registers
  logic        en;
  logic [6:0]  interface_mode_select;
  logic [7:0]  multiframe_frames_minus_one;
  logic [14:0] overrange_threshold_zero;
  logic [14:0] overrange_threshold_one;

  // mode decode
  jtl_mode_t   cfg;
  logic [8:0]  k_req;
  logic [8:0]  k_off;
  logic        k_legal;
  logic [8:0]  k_eff;
  logic        run;
  logic [3:0]  lane_cnt;
  logic [3:0]  m_per_link;
  logic [7:0]  lane_mask;

  // packer
  logic        drain_valid;
  logic        drain_ready;
  jtl_beat_t   beat;
  logic        take;
  logic        load;
  logic [5:0]  kcnt;
  logic [5:0]  beats;
  logic [2:0]  lane;
  logic [2:0]  slot;
  logic [6:0]  pos;
  logic        fill_full;
  logic        iq_ph;
  logic        flag_a;
  logic        flag_b;
  logic [15:0] word_a;
  logic [15:0] word_b;
  logic [LANES-1:0][63:0] frame_a;
  logic [LANES-1:0][63:0] frame_b;

  // output shifter
  logic [LANES-1:0][63:0] sh_a;
  logic [LANES-1:0][63:0] sh_b;
  logic        busy;
  logic [3:0]  ocnt;
  logic        out_last;
  logic [8:0]  fcnt;

  // apb decode
  logic        acc;
  logic        mapped;

  ////////////////////////////////////////////////////////////////////
  // mode fields follow the one mode-select value, k comes from its own register
  assign cfg   = jtl_mode_lookup(interface_mode_select);
  assign k_req = 9'(multiframe_frames_minus_one) + K_ONE;
  assign k_off = k_req - cfg.k_min;

  // step is a power of two, so a mask checks alignment
  assign k_legal = !cfg.enc8 || (k_req >= cfg.k_min && k_req <= cfg.k_max
                   && (k_off & (cfg.k_step - K_ONE)) == 9'h000);
  // fixed multiframe length on the 64b/66b side
  assign k_eff = cfg.enc8 ? k_req
               : (cfg.f == 4'h0) ? 9'h000 : K_NUM / 9'(cfg.f);

  // an unlisted mode or a bad k keeps every lane down
  assign run      = en && cfg.valid && k_legal;
  assign lane_cnt = 4'h1 << cfg.l_log2;
  assign m_per_link = cfg.m_eq_l ? lane_cnt
                    : (cfg.dual ? 4'h2 : 4'h1);
  // both links share one lane count, lowest lanes first
  assign lane_mask      = run ? ~(8'hff << lane_cnt) : 8'h00;
  assign link_a_lane_en = lane_mask;
  assign link_b_lane_en = lane_mask;

  // fixed lane numbering inside each link
  for (genvar i = 0; i < LANES; i++) begin : g_lid
    assign link_a_lane_id[i] = 3'(i);
    assign link_b_lane_id[i] = 3'(i);
  end

  ////////////////////////////////////////////////////////////////////
  // zero-wait slave: read data is caught in the setup cycle
  assign pready = 1'b1;
  assign acc    = psel && penable;
  assign mapped = paddr == ADDR_CTRL || paddr == ADDR_MODE || paddr == ADDR_KM1
               || paddr == ADDR_DID || paddr == ADDR_THR0 || paddr == ADDR_THR1
               || paddr == ADDR_STAT;
  assign pslverr = acc && !mapped;

  // register writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      en                          <= 1'b0;
      interface_mode_select       <= MODE_RST;
      multiframe_frames_minus_one <= KM1_RST;
      link_a_did                  <= DID_RST;
      link_b_did                  <= DID_RST + 8'h01;
      overrange_threshold_zero    <= THR_RST;
      overrange_threshold_one     <= THR_RST;
    end else if (acc && pwrite) begin
      case (paddr)
        ADDR_CTRL: en <= pwdata[CTRL_EN];
        ADDR_MODE: interface_mode_select <= pwdata[6:0];
        ADDR_KM1:  multiframe_frames_minus_one <= pwdata[7:0];
        ADDR_DID: begin
          link_a_did <= pwdata[7:0];
          link_b_did <= pwdata[7:0] + 8'h01;
        end
        ADDR_THR0: overrange_threshold_zero <= pwdata[14:0];
        ADDR_THR1: overrange_threshold_one <= pwdata[14:0];
        default: ;
      endcase
    end
  end

  // read mux, status shows the decoded mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        ADDR_CTRL: prdata <= {31'h0, en};
        ADDR_MODE: prdata <= {25'h0, interface_mode_select};
        ADDR_KM1:  prdata <= {24'h0, multiframe_frames_minus_one};
        ADDR_DID:  prdata <= {24'h0, link_a_did};
        ADDR_THR0: prdata <= {17'h0, overrange_threshold_zero};
        ADDR_THR1: prdata <= {17'h0, overrange_threshold_one};
        ADDR_STAT: prdata <= {8'h0, k_eff, cfg.f, m_per_link, lane_cnt,
                              run, k_legal, cfg.valid};
        default:   prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  jtl_fifo #(
    .WIDTH ($bits(jtl_beat_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .wr_valid (in_valid),
    .wr_ready (in_ready),
    .wr_data  (in_beat),
    .rd_valid (drain_valid),
    .rd_ready (drain_ready),
    .rd_data  (beat)
  );

  // a full frame waits for the shifter, which stalls the fifo
  assign drain_ready = run && !fill_full;
  assign take        = drain_valid && drain_ready;
  assign load        = run && fill_full && !busy;

  // beat k goes to lane k mod L, slot k div L on both links
  assign beats = 6'(cfg.slots) << cfg.l_log2;
  assign lane  = kcnt[2:0] & 3'(lane_cnt - 4'h1);
  assign slot  = 3'(kcnt >> cfg.l_log2);
  // msb of each word sits at the highest free position
  assign pos   = TOP_BIT - (cfg.ddc ? {slot, 4'h0}
                                    : 7'(slot) * 7'd12);

  // magnitude test of a signed 15-bit word
  function automatic logic over(input logic [14:0] s, input logic [14:0] t);
    logic [14:0] mag;
    mag = s[14] ? 15'(~s + 15'h0001) : s;
    return mag > t;
  endfunction

  // dual: both converters alternate i/q, i against threshold zero
  // single: a carries i, b carries q
  assign flag_a = over(beat.a[14:0], (cfg.dual && iq_ph)
                  ? overrange_threshold_one : overrange_threshold_zero);
  assign flag_b = over(beat.b[14:0], (cfg.dual && !iq_ph)
                  ? overrange_threshold_zero : overrange_threshold_one);

  // a feeds link a, b feeds link b, for both converter streams
  assign word_a = cfg.ddc ? {beat.a[14:0], flag_a}
                          : {beat.a[11:0], 4'h0};
  assign word_b = cfg.ddc ? {beat.b[14:0], flag_b}
                          : {beat.b[11:0], 4'h0};

  // frame assembly; cleared frames leave the tail at zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      kcnt      <= '0;
      fill_full <= 1'b0;
      iq_ph     <= 1'b0;
      frame_a   <= '0;
      frame_b   <= '0;
    end else if (!run) begin
      // a stop, an unlisted mode or a bad k drops the partial frame
      kcnt      <= '0;
      fill_full <= 1'b0;
      iq_ph     <= 1'b0;
      frame_a   <= '0;
      frame_b   <= '0;
    end else if (load) begin
      fill_full <= 1'b0;
      frame_a   <= '0;
      frame_b   <= '0;
    end else if (take) begin
      frame_a[lane][pos -: 16] <= word_a;
      frame_b[lane][pos -: 16] <= word_b;
      iq_ph <= cfg.ddc && cfg.dual && !iq_ph;
      if (kcnt == beats - 6'h01) begin
        kcnt      <= '0;
        fill_full <= 1'b1;
      end else begin
        kcnt <= kcnt + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // octet shifter: f octets per frame, one per clock, msb first
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sh_a           <= '0;
      sh_b           <= '0;
      busy           <= 1'b0;
      ocnt           <= '0;
      octet_valid    <= 1'b0;
      frame_start    <= 1'b0;
      out_last       <= 1'b0;
      multiframe_end <= 1'b0;
      fcnt           <= '0;
      link_a_lane    <= '0;
      link_b_lane    <= '0;
    end else begin
      frame_start    <= 1'b0;
      out_last       <= 1'b0;
      multiframe_end <= 1'b0;
      octet_valid    <= busy;
      if (!run) begin
        fcnt <= '0;
      end
      if (load) begin
        sh_a <= frame_a;
        sh_b <= frame_b;
        busy <= 1'b1;
        ocnt <= '0;
      end
      for (int i = 0; i < LANES; i++) begin
        // powered-down lanes stay at zero
        link_a_lane[i] <= (busy && lane_mask[i]) ? sh_a[i][63:56] : 8'h00;
        link_b_lane[i] <= (busy && lane_mask[i]) ? sh_b[i][63:56] : 8'h00;
      end
      if (busy) begin
        for (int i = 0; i < LANES; i++) begin
          sh_a[i] <= {sh_a[i][55:0], 8'h00};
          sh_b[i] <= {sh_b[i][55:0], 8'h00};
        end
        frame_start <= ocnt == 4'h0;
        ocnt        <= ocnt + 4'h1;
        if (ocnt == cfg.f - 4'h1) begin
          busy     <= 1'b0;
          out_last <= 1'b1;
          if (fcnt >= k_eff - K_ONE) begin
            fcnt           <= '0;
            multiframe_end <= 1'b1;
          end else if (run) begin
            fcnt <= fcnt + K_ONE;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  a_mode_only : assert property (@(posedge ref_clk) disable iff (rst)
    !cfg.valid |-> link_a_lane_en == 8'h00 && link_b_lane_en == 8'h00)
    else $error("lanes enabled in an unlisted mode");

  a_k_block : assert property (@(posedge ref_clk) disable iff (rst)
    (!run && !busy) |=> !busy ##1 !frame_start)
    else $error("frames sent with illegal k or stopped mode");

  a_mf_on_last : assert property (@(posedge ref_clk) disable iff (rst)
    multiframe_end |-> out_last && octet_valid)
    else $error("multiframe end off a frame boundary");

  a_lane_count : assert property (@(posedge ref_clk) disable iff (rst)
    run |-> link_a_lane_en[0] && !link_a_lane_en[lane_cnt[2:0]] == (lane_cnt != 4'h8))
    else $error("wrong lanes powered");

  a_did_pair : assert property (@(posedge ref_clk) disable iff (rst)
    link_b_did == link_a_did + 8'h01)
    else $error("link b identifier not link a plus one");

  a_did_write : assert property (@(posedge ref_clk) disable iff (rst)
    (acc && pwrite && paddr == ADDR_DID) |=> link_a_did == $past(pwdata[7:0]))
    else $error("link a identifier not the written value");

  a_tail_zero : assert property (@(posedge ref_clk) disable iff (rst)
    (out_last && !cfg.ddc) |-> link_a_lane[0][3:0] == 4'h0
                               && link_b_lane[0][3:0] == 4'h0)
    else $error("tail bits not zero");

  a_msb_first : assert property (@(posedge ref_clk) disable iff (rst)
    (take && kcnt == 6'h00 && !cfg.ddc)
      |=> frame_a[0][63:52] == $past(beat.a[11:0]))
    else $error("raw sample not at frame msb");

  a_ddc_flag : assert property (@(posedge ref_clk) disable iff (rst)
    (take && kcnt == 6'h00 && cfg.ddc && !cfg.dual)
      |=> frame_b[0][48] == $past(flag_b) && frame_b[0][63:49] == $past(beat.b[14:0]))
    else $error("down-converter word layout wrong");

  a_frame_len : assert property (@(posedge ref_clk) disable iff (rst)
    (frame_start && cfg.f == 4'h2 && $stable(cfg)) |=> out_last)
    else $error("two-octet frame length wrong");

  a_stall_full : assert property (@(posedge ref_clk) disable iff (rst)
    (fill_full && busy) |-> !drain_ready ##1 (fill_full || !$past(run)))
    else $error("drain not stalled on full frame");
endmodule

// File: design/jtl_pkg.sv
// jtl_pkg: constants, mode table and carriers of the lane mapper
package jtl_pkg;
  localparam int         LANES     = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_KM1  = 8'h08;
  localparam logic [7:0] ADDR_DID  = 8'h0c;
  localparam logic [7:0] ADDR_THR0 = 8'h10;
  localparam logic [7:0] ADDR_THR1 = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam int         CTRL_EN   = 0;
  localparam logic [6:0]  MODE_RST = 7'h00;
  localparam logic [7:0]  KM1_RST  = 8'h1f;
  localparam logic [7:0]  DID_RST  = 8'h00;
  localparam logic [14:0] THR_RST  = 15'h7fff;
  // 8*32*E with E fixed at one
  localparam logic [8:0]  K_NUM    = 9'h100;
  localparam logic [8:0]  K_ONE    = 9'h001;
  localparam logic [6:0]  TOP_BIT  = 7'h3f;

  typedef struct packed {
    logic       valid;
    logic       ddc;
    logic       dual;
    logic       enc8;
    logic       m_eq_l;
    logic [1:0] l_log2;
    logic [3:0] f;
    logic [2:0] slots;
    logic [8:0] k_min;
    logic [8:0] k_step;
    logic [8:0] k_max;
  } jtl_mode_t;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
  } jtl_beat_t;

  function automatic jtl_mode_t jtl_mode_lookup(input logic [6:0] m);
    jtl_mode_t c;
    c = '0;
    case (m)
      7'h00:   c = {5'b10001, 2'd2, 4'h8, 3'h5, 27'h0};
      7'h01:   c = {5'b10001, 2'd3, 4'h8, 3'h5, 27'h0};
      7'h02:   c = {5'b10101, 2'd2, 4'h8, 3'h5, 27'h0};
      7'h03:   c = {5'b10101, 2'd3, 4'h8, 3'h5, 27'h0};
      7'h2f:   c = {5'b11100, 2'd2, 4'h2, 3'h1, 27'h0};
      7'h35:   c = {5'b11100, 2'd3, 4'h2, 3'h1, 27'h0};
      7'h38:   c = {5'b11110, 2'd0, 4'h4, 3'h2, 9'd8, 9'd4, 9'd256};
      7'h3a:   c = {5'b11110, 2'd2, 4'h2, 3'h1, 9'd16, 9'd8, 9'd256};
      7'h3d:   c = {5'b11010, 2'd0, 4'h2, 3'h1, 9'd16, 9'd8, 9'd256};
      7'h3f:   c = {5'b11010, 2'd2, 4'h2, 3'h1, 9'd16, 9'd8, 9'd256};
      default: c = '0;
    endcase
    return c;
  endfunction
endpackage

// File: test/jtl_rx_model.sv
// jtl_rx_model: far-side receiver that gathers each lane's frame octets
`timescale 1ns/1ns

module jtl_rx_model
  import jtl_pkg::*;
(
  // clock
  input wire logic                  ref_clk,
  // lanes of both links
  input wire logic [LANES-1:0][7:0] link_a_lane,
  input wire logic [LANES-1:0][7:0] link_b_lane,
  // framing marks
  input wire logic                  octet_valid,
  input wire logic                  frame_start,
  input wire logic                  multiframe_end
);
  logic [LANES-1:0][63:0] acc_a;
  logic [LANES-1:0][63:0] acc_b;
  int                     n_frame  = 0;
  int                     n_mframe = 0;

  ////////////////////////////////////////////////////////////////////////
  // first octet lands deepest; the bench checks each lane against its own beats from the queue
  always @(posedge ref_clk) begin
    if (octet_valid) begin
      for (int l = 0; l < LANES; l++) begin
        acc_a[l] <= {(frame_start ? 56'h0 : acc_a[l][55:0]), link_a_lane[l]};
        acc_b[l] <= {(frame_start ? 56'h0 : acc_b[l][55:0]), link_b_lane[l]};
      end
      if (frame_start) n_frame <= n_frame + 1;
      if (multiframe_end) n_mframe <= n_mframe + 1;
    end
  end
endmodule

// File: test/testbench.sv
// testbench: register and sample-stream checks of the lane mapper
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module testbench
  import jtl_pkg::*;
;
  logic                   ref_clk  = 1'b0;
  logic                   rst      = 1'b1;
  logic                   psel     = 1'b0;
  logic                   penable  = 1'b0;
  logic                   pwrite   = 1'b0;
  logic [7:0]             paddr    = 8'h00;
  logic [31:0]            pwdata   = 32'h0;
  logic                   in_valid = 1'b0;
  jtl_beat_t              in_beat  = '0;
  logic [31:0]            prdata, rq;
  logic                   pready, pslverr, in_ready, re;
  logic [LANES-1:0][7:0]  link_a_lane, link_b_lane;
  logic [LANES-1:0]       link_a_lane_en, link_b_lane_en;
  logic [LANES-1:0][2:0]  link_a_lane_id, link_b_lane_id;
  logic [7:0]             link_a_did, link_b_did;
  logic                   octet_valid, frame_start, multiframe_end;
  int                     n_mismatch = 0;
  int                     tests_run  = 0;
  int                     i, l, s, n0;
  jtl_beat_t              q[$];
  logic [63:0]            e;
  logic [15:0]            av[4] = '{16'h0200, 16'h7e00, 16'h0100, 16'h00ff};

  jtl_transport_mapper #(.FIFO_DEPTH(8)) uut (.ref_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_ready, .in_beat,
    .link_a_lane, .link_a_lane_en, .link_a_lane_id, .link_a_did, .link_b_lane,
    .link_b_lane_en, .link_b_lane_id, .link_b_did, .octet_valid, .frame_start,
    .multiframe_end);
  jtl_rx_model rx (.ref_clk, .link_a_lane, .link_b_lane, .octet_valid, .frame_start,
    .multiframe_end);

  ////////////////////////////////////////////////////////////////////////
  // 100 ns clock
  initial forever #50 ref_clk = ~ref_clk;

  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic tmo(input int t, input int n);
    if (t >= n) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  // one apb transfer; idle edge first so back-to-back calls never collide
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int t;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (t = 0; t < 16; t++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    tmo(t, 16);
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // let the written state settle before callers look at it
    @(negedge ref_clk);
  endtask

  // pushes q[lo..hi-1], valid held high between beats
  task automatic send(input int lo, input int hi);
    int t;
    @(posedge ref_clk);
    for (int k = lo; k < hi; k++) begin
      in_valid <= 1'b1;
      in_beat  <= q[k];
      for (t = 0; t < 200; t++) begin
        @(posedge ref_clk);
        if (in_ready === 1'b1) break;
      end
      tmo(t, 200);
    end
    in_valid <= 1'b0;
  endtask

  task automatic wait_fr(input int n);
    int t;
    n0 = rx.n_frame;
    for (t = 0; t < 400; t++) begin
      @(negedge ref_clk);
      if (rx.n_frame >= n0 + n && octet_valid === 1'b0) break;
    end
    tmo(t, 400);
  endtask

  function automatic logic [15:0] word(input logic [15:0] x, input logic [14:0] t);
    logic [14:0] m;
    m = x[14] ? 15'(-x[14:0]) : x[14:0];
    return {x[14:0], m > t};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge ref_clk);
    `CHK({link_a_did, link_b_did}, 16'h0001)
    @(posedge ref_clk);
    rst <= 1'b0;
    // reset values, unmapped place, fixed lane numbering
    for (i = 0; i < 6; i++) begin
      apb(8'(4 * i), 1'b0, 32'h0);
      `CHK(rq, i < 2 ? 32'h0 : i == 2 ? 32'h1f : i == 3 ? 32'h0 : 32'h7fff)
    end
    apb(8'h1c, 1'b0, 32'h0);
    `CHK(re, 1'b1)
    for (l = 0; l < LANES; l++) `CHK({link_a_lane_id[l], link_b_lane_id[l]}, 6'(9 * l))
    // device identifiers, including the wrap of the second link
    foreach (av[i]) begin
      apb(ADDR_DID, 1'b1, {24'h0, av[i][7:0] ^ 8'hff});
      `CHK(link_a_did, av[i][7:0] ^ 8'hff)
      `CHK(link_b_did, 8'((av[i][7:0] ^ 8'hff) + 8'h01))
    end
    // only listed mode values are accepted
    for (i = 0; i < 128; i += 3) begin
      apb(ADDR_MODE, 1'b1, 32'(i));
      apb(ADDR_STAT, 1'b0, 32'h0);
      `CHK(rq[0], 1'(i inside {0, 3, 47, 53, 63}))
    end
    apb(ADDR_MODE, 1'b1, 32'h2f);
    apb(ADDR_STAT, 1'b0, 32'h0);
    `CHK(rq[23:15], 9'd128)
    // raw mode: fill the idle buffer until it refuses, then run a frame
    apb(ADDR_MODE, 1'b1, 32'h00);
    apb(ADDR_STAT, 1'b0, 32'h0);
    `CHK(rq[23:3], {9'd32, 4'h8, 4'h4, 4'h4})
    for (i = 0; i < 20; i++) q.push_back({4'h0, 12'(i * 317 + 5), 4'h0, 12'(i * 611 + 9)});
    send(0, 8);
    @(negedge ref_clk);
    `CHK(in_ready, 1'b0)
    apb(ADDR_CTRL, 1'b1, 32'h1);
    `CHK({link_a_lane_en, link_b_lane_en}, 16'h0f0f)
    send(8, 20);
    wait_fr(1);
    for (l = 0; l < 4; l++) begin
      e = 64'h0;
      for (s = 0; s < 5; s++) e = {e[51:0], q[l + 4 * s].a[11:0]};
      `CHK(rx.acc_a[l], {e[59:0], 4'h0})
      e = 64'h0;
      for (s = 0; s < 5; s++) e = {e[51:0], q[l + 4 * s].b[11:0]};
      `CHK(rx.acc_b[l], {e[59:0], 4'h0})
    end
    `CHK(rx.acc_a[4], 64'h0)
    // single down-converter mode, an illegal K first, then K of 16 frames
    apb(ADDR_CTRL, 1'b1, 32'h0);
    apb(ADDR_MODE, 1'b1, 32'h3d);
    apb(ADDR_THR0, 1'b1, 32'h100);
    apb(ADDR_THR1, 1'b1, 32'h0);
    apb(ADDR_KM1, 1'b1, 32'h10);
    apb(ADDR_CTRL, 1'b1, 32'h1);
    apb(ADDR_STAT, 1'b0, 32'h0);
    `CHK({rq[2:1], link_a_lane_en}, 10'h0)
    apb(ADDR_KM1, 1'b1, 32'h0f);
    `CHK({link_a_lane_en, link_b_lane_en}, 16'h0101)
    s = rx.n_mframe;
    for (i = 0; i < 16; i++) begin
      q[0] = {av[i % 4], av[(i + 1) % 4]};
      send(0, 1);
      wait_fr(1);
      `CHK(rx.acc_a[0][15:0], word(q[0].a, 15'h100))
      `CHK(rx.acc_b[0][15:0], word(q[0].b, 15'h0))
    end
    `CHK(rx.n_mframe - s, 1)
    // dual mode: i then q word per lane, separate converter streams
    apb(ADDR_CTRL, 1'b1, 32'h0);
    apb(ADDR_MODE, 1'b1, 32'h38);
    apb(ADDR_KM1, 1'b1, 32'h07);
    apb(ADDR_CTRL, 1'b1, 32'h1);
    q[0] = {av[0], av[3]};
    q[1] = {av[2], av[1]};
    send(0, 2);
    wait_fr(1);
    `CHK(rx.acc_a[0][31:0], {word(av[0], 15'h100), word(av[2], 15'h0)})
    `CHK(rx.acc_b[0][31:0], {word(av[3], 15'h100), word(av[1], 15'h0)})
    stop_test();
  end
endmodule
